// ### design/backoff_engine.sv
// One per-category backoff counter
`timescale 1ns/1ps
`include "chan_timing_regs.svh"
module backoff_engine (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  input  wire logic                 clk_en,
  // Load from the sequencer
  input  wire logic                 load,
  input  wire logic [`BO_W-1:0]     load_value,
  // Slot sampling
  input  wire logic                 slot_end,
  input  wire logic                 slot_idle,
  // State
  output logic      [`BO_W-1:0]     count_q,
  output logic                      zero_q
);
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count_q <= '0;
      zero_q  <= `RST_ZERO;
    end else if (clk_en) begin
      zero_q <= 1'b0;
      if (load) begin
        count_q <= load_value;
      end else if (slot_end && slot_idle && count_q != '0) begin // R3 R17
        count_q <= count_q - `BO_W'(1);
        zero_q  <= (count_q == `BO_W'(1));
      end
    end
  end

  property p_bo_step;
    @(posedge clk) disable iff (sys_rst)
    clk_en && !load && slot_end && slot_idle && count_q != '0 |=> count_q == $past(count_q) - `BO_W'(1);
  endproperty
  a_bo_step: assert property (p_bo_step) else $error("backoff did not decrement in idle slot"); // R17

  property p_bo_hold;
    @(posedge clk) disable iff (sys_rst)
    clk_en && !load && !(slot_end && slot_idle) |=> $stable(count_q) && !zero_q;
  endproperty
  a_bo_hold: assert property (p_bo_hold) else $error("backoff moved without idle slot end"); // R3
endmodule : backoff_engine

// ### design/chan_access_timing.sv
// Channel-access timing core: spacing, backoff, virtual busy, sync timer, sleep
// Contract
// R1 - Spacing timers start when the PHY shows medium activity has ceased.
// R2 - One independent backoff engine per access category.
// R3 - Each backoff engine samples activity once per slot: count down or hold.
// R4 - Backoff reaching zero notifies the transmit engine.
// R5 - Simultaneous zeros: exactly one granted, by sequencer-programmed priority.
// R6 - Spacing timers give a precise start trigger for responses and bursts.
// R7 - A scheduled frame starts only on the spacing or backoff trigger.
// R8 - Power-save gates the MAC main clock off.
// R9 - Slow-clock sleep timer sets suspend time; sequencer loads it first.
// R10 - Sleep expiry re-enables the MAC clock and function.
// R11 - Sequencer advances the sync timer by the slept time after waking.
// R12 - Sync timer loads a received timestamp on sequencer command.
// R13 - A beacon target time is kept beside the sync timer.
// R14 - Trigger pulses when the sync timer reaches programmed offsets.
// R15 - Virtual busy timer updated from received duration fields.
// R16 - Virtual busy state feeds the spacing unit as carrier sense.
// R17 - Backoff decrements after each fully idle slot, else holds.
// R18 - Virtual busy counts down, only larger values replace it.
`timescale 1ns/1ps
`include "chan_timing_regs.svh"
module chan_access_timing (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          sys_rst,
  input  wire logic                          clk_en,
  // PHY activity and slow clock pins
  input  wire logic                          phy_busy,
  input  wire logic                          slow_clk,
  // Sequencer control
  input  wire chan_timing_pkg::policy_type   policy,
  input  wire chan_timing_pkg::bo_cmd_type   bo_cmd,
  input  wire chan_timing_pkg::tsf_cmd_type  tsf_cmd,
  input  wire chan_timing_pkg::nav_cmd_type  nav_cmd,
  input  wire chan_timing_pkg::sleep_cmd_type sleep_cmd,
  // Transmit engine
  input  wire chan_timing_pkg::tx_req_type   tx_req,
  output logic                               tx_start,
  output logic      [1:0]                    tx_start_ac,
  output logic      [`AC_NUM-1:0]            bo_notify,
  output logic                               ifs_trig,
  // Status to the sequencer
  output logic      [`TSF_W-1:0]             tsf_time,
  output logic      [2:0]                    tsf_evt,
  output logic                               nav_busy,
  output logic      [`SLEEP_W-1:0]           slept_ticks,
  output logic                               wake_evt,
  // Clock gate of the MAC
  output logic                               mac_clk_en
);
  logic                     busy_m_q, busy_s_q, busy_p_q;
  logic                     lpo_m_q, lpo_s_q, lpo_p_q;
  logic [`NAV_W-1:0]        nav_q;
  logic [`TMR_W-1:0]        us_cnt_q, ifs_cnt_q, slot_cnt_q;
  logic                     ifs_run_q, ifs_done_q, slot_busy_q;
  logic [`AC_NUM-1:0]       zero_vec, notify_q;
  logic [`AC_NUM-1:0][`BO_W-1:0] bo_count;
  logic                     grant_q;
  logic [1:0]               grant_ac_q;
  logic                     sched_q, resp_q;
  logic [1:0]               sched_ac_q;
  logic                     start_q;
  logic [1:0]               start_ac_q;
  logic [`TSF_W-1:0]        tsf_q, beacon_target_time_q, ul_q, dl_q;
  logic [2:0]               evt_q;
  chan_timing_pkg::pwr_state_type pwr_q;
  logic [`SLEEP_W-1:0]      sleep_cnt_q, slept_q;
  logic                     wake_q;
  logic                     us_tick, lpo_tick, medium_idle, busy_fall, slot_end, slot_idle, trig_hit;
  logic [2:0]               win;
  logic [`TSF_W-1:0]        tsf_inc;
  logic                     tsf_step;

  // Lowest rank value wins; ties go to the lower category index
  function automatic logic [2:0] pick(input logic [`AC_NUM-1:0] req,
                                      input logic [`AC_NUM-1:0][1:0] rank);
    logic [2:0] best;
    best = 3'h4;
    for (int i = 0; i < `AC_NUM; i++) begin
      if (req[i] && (best[2] || rank[i] < rank[best[1:0]])) begin
        best = {1'b0, 2'(i)};
      end
    end
    return best;
  endfunction : pick

  // Two-stage synchronisers; third stage only for edge detection
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      {busy_m_q, busy_s_q, busy_p_q} <= 3'h0;
      {lpo_m_q, lpo_s_q, lpo_p_q}    <= 3'h0;
    end else if (clk_en) begin
      {busy_m_q, busy_s_q, busy_p_q} <= {phy_busy, busy_m_q, busy_s_q};
      {lpo_m_q, lpo_s_q, lpo_p_q}    <= {slow_clk, lpo_m_q, lpo_s_q};
    end
  end

  assign lpo_tick    = lpo_s_q & ~lpo_p_q;
  assign us_tick     = (us_cnt_q == `TMR_W'(`US_CYC - 1));
  assign medium_idle = ~busy_s_q & ~nav_busy; // R16
  assign busy_fall   = busy_p_q & ~busy_s_q;
  assign slot_end    = (slot_cnt_q == `TMR_W'(`SLOT_CYC - 1));
  assign slot_idle   = ifs_done_q & ~slot_busy_q & medium_idle;

  // Microsecond prescaler shared by sync and virtual busy timers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      us_cnt_q <= '0;
    end else if (clk_en) begin
      us_cnt_q <= us_tick ? '0 : us_cnt_q + `TMR_W'(1);
    end
  end

  // Virtual busy timer; a shorter new duration never truncates protection
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      nav_q <= '0;
    end else if (clk_en) begin
      if (nav_cmd.update && nav_cmd.duration > nav_q) begin // R15 R18
        nav_q <= nav_cmd.duration;
      end else if (us_tick && nav_q != '0) begin // R18
        nav_q <= nav_q - `NAV_W'(1);
      end
    end
  end
  assign nav_busy = (nav_q != '0);

  // Spacing timer: restarts on each end of physical activity
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ifs_run_q  <= 1'b0;
      ifs_done_q <= 1'b0;
      ifs_cnt_q  <= '0;
      ifs_trig   <= 1'b0;
    end else if (clk_en) begin
      ifs_trig <= 1'b0;
      if (!medium_idle) begin
        ifs_run_q  <= 1'b0;
        ifs_done_q <= 1'b0;
      end
      if (busy_fall) begin // R1
        ifs_run_q <= 1'b1;
        ifs_cnt_q <= policy.use_rifs ? `TMR_W'(`RIFS_CYC - 1) : `TMR_W'(`SIFS_CYC - 1);
      end else if (ifs_run_q && medium_idle) begin
        if (ifs_cnt_q == '0) begin // R6
          ifs_run_q  <= 1'b0;
          ifs_done_q <= 1'b1;
          ifs_trig   <= 1'b1;
        end else begin
          ifs_cnt_q <= ifs_cnt_q - `TMR_W'(1);
        end
      end
    end
  end

  // Slot clock; a slot counts as idle only if no activity was seen in it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      slot_cnt_q  <= '0;
      slot_busy_q <= 1'b0;
    end else if (clk_en) begin
      slot_cnt_q  <= slot_end ? '0 : slot_cnt_q + `TMR_W'(1);
      slot_busy_q <= slot_end ? 1'b0 : (slot_busy_q | ~medium_idle); // R3
    end
  end

  for (genvar g = 0; g < `AC_NUM; g++) begin : g_bo // R2
    backoff_engine u_bo (
      .clk        (clk),
      .sys_rst    (sys_rst),
      .clk_en     (clk_en),
      .load       (bo_cmd.load && bo_cmd.ac == 2'(g)),
      .load_value (bo_cmd.value),
      .slot_end   (slot_end),
      .slot_idle  (slot_idle),
      .count_q    (bo_count[g]),
      .zero_q     (zero_vec[g])
    );
  end

  // Notification and single grant among simultaneous zeros
  assign win = pick(zero_vec, policy.rank);
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      notify_q   <= '0;
      grant_q    <= 1'b0;
      grant_ac_q <= 2'h0;
    end else if (clk_en) begin
      notify_q   <= zero_vec; // R4
      grant_q    <= ~win[2]; // R5
      grant_ac_q <= win[1:0];
    end
  end
  assign bo_notify = notify_q;

  // Scheduled frame waits for its timing trigger
  assign trig_hit = resp_q ? ifs_trig : (grant_q && grant_ac_q == sched_ac_q);
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sched_q    <= 1'b0;
      resp_q     <= 1'b0;
      sched_ac_q <= 2'h0;
      start_q    <= 1'b0;
      start_ac_q <= 2'h0;
    end else if (clk_en) begin
      start_q <= 1'b0;
      if (tx_req.sched) begin
        sched_q    <= 1'b1;
        resp_q     <= tx_req.response;
        sched_ac_q <= tx_req.ac;
      end else if (sched_q && trig_hit) begin // R7
        sched_q    <= 1'b0;
        start_q    <= 1'b1;
        start_ac_q <= sched_ac_q;
      end
    end
  end
  assign tx_start    = start_q;
  assign tx_start_ac = start_ac_q;

  // Sync timer, beacon target and offset triggers
  assign tsf_inc  = tsf_q + `TSF_W'(1);
  assign tsf_step = us_tick && tsf_cmd.op != chan_timing_pkg::TSF_LOAD && tsf_cmd.op != chan_timing_pkg::TSF_ADVANCE;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tsf_q  <= '0;
      beacon_target_time_q <= '0;
      ul_q   <= '0;
      dl_q   <= '0;
      evt_q  <= 3'h0;
    end else if (clk_en) begin
      // Compare the value being entered, so the pulse coincides with the timer showing it
      evt_q <= tsf_step ? {tsf_inc == dl_q, tsf_inc == ul_q, tsf_inc == beacon_target_time_q} : 3'h0; // R13 R14
      case (tsf_cmd.op)
        chan_timing_pkg::TSF_LOAD:     tsf_q <= tsf_cmd.value; // R12
        chan_timing_pkg::TSF_ADVANCE:  tsf_q <= tsf_q + tsf_cmd.value; // R11
        chan_timing_pkg::TSF_SET_BEACON_TARGET_TIME: beacon_target_time_q <= tsf_cmd.value; // R13
        chan_timing_pkg::TSF_SET_UL:   ul_q <= tsf_cmd.value;
        chan_timing_pkg::TSF_SET_DL:   dl_q <= tsf_cmd.value;
        default: ;
      endcase
      if (tsf_step) begin
        tsf_q <= tsf_inc;
      end
    end
  end
  assign tsf_time = tsf_q;
  assign tsf_evt  = evt_q;

  // Power save: MAC clock off until the slow-clock count runs out
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pwr_q       <= chan_timing_pkg::PWR_AWAKE;
      sleep_cnt_q <= '0;
      slept_q     <= '0;
      wake_q      <= 1'b0;
    end else if (clk_en) begin
      wake_q <= 1'b0;
      case (pwr_q)
        chan_timing_pkg::PWR_AWAKE: begin
          if (sleep_cmd.load) begin // R9
            sleep_cnt_q <= sleep_cmd.count;
          end else if (sleep_cmd.enter && sleep_cnt_q != '0) begin // R8
            pwr_q   <= chan_timing_pkg::PWR_SLEEP;
            slept_q <= '0;
          end
        end
        chan_timing_pkg::PWR_SLEEP: begin
          if (lpo_tick) begin
            slept_q     <= slept_q + `SLEEP_W'(1);
            sleep_cnt_q <= sleep_cnt_q - `SLEEP_W'(1);
            if (sleep_cnt_q == `SLEEP_W'(1)) begin // R10
              pwr_q  <= chan_timing_pkg::PWR_AWAKE;
              wake_q <= 1'b1;
            end
          end
        end
        default: pwr_q <= chan_timing_pkg::PWR_AWAKE;
      endcase
    end
  end
  assign mac_clk_en  = (pwr_q == chan_timing_pkg::PWR_AWAKE);
  assign wake_evt    = wake_q;
  assign slept_ticks = slept_q;

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_ifs_start;
    clk_en && busy_fall ##1 clk_en && !busy_s_q && !nav_busy |-> ifs_run_q || ifs_trig;
  endproperty
  a_ifs_start: assert property (p_ifs_start) else $error("spacing timer did not start"); // R1

  property p_notify;
    clk_en && zero_vec != '0 |=> bo_notify == $past(zero_vec);
  endproperty
  a_notify: assert property (p_notify) else $error("zero backoff not notified"); // R4

  property p_zero_cnt;
    zero_vec != '0 |->
      (zero_vec & {bo_count[3] != '0, bo_count[2] != '0, bo_count[1] != '0, bo_count[0] != '0}) == '0;
  endproperty
  a_zero_cnt: assert property (p_zero_cnt) else $error("zero pulse with nonzero backoff"); // R4

  property p_grant_one;
    clk_en && $countones(zero_vec) > 1 |=> grant_q && zero_vec[grant_ac_q] == 1'b0 &&
      |($past(zero_vec) & (`AC_NUM'(1) << grant_ac_q));
  endproperty
  a_grant_one: assert property (p_grant_one) else $error("conflict not resolved to one"); // R5

  property p_tx_start;
    tx_start |-> $past(sched_q) && $past(trig_hit) && tx_start_ac == $past(sched_ac_q);
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("frame started without trigger"); // R7

  property p_clk_off;
    clk_en && mac_clk_en && sleep_cmd.enter && !sleep_cmd.load && sleep_cnt_q != '0 |=> !mac_clk_en;
  endproperty
  a_clk_off: assert property (p_clk_off) else $error("MAC clock not gated on sleep"); // R8

  property p_wake;
    wake_evt |-> mac_clk_en && !$past(mac_clk_en) && $past(sleep_cnt_q) == `SLEEP_W'(1);
  endproperty
  a_wake: assert property (p_wake) else $error("wake without expiry"); // R10

  property p_tsf_load;
    clk_en && tsf_cmd.op == chan_timing_pkg::TSF_LOAD |=> tsf_time == $past(tsf_cmd.value);
  endproperty
  a_tsf_load: assert property (p_tsf_load) else $error("sync timer did not load timestamp"); // R12

  property p_nav_upd;
    clk_en && nav_cmd.update && nav_cmd.duration > nav_q |=> nav_q == $past(nav_cmd.duration) && nav_busy;
  endproperty
  a_nav_upd: assert property (p_nav_upd) else $error("virtual busy not updated"); // R15

  property p_nav_cs;
    nav_busy |-> !medium_idle ##1 (!clk_en || !ifs_trig);
  endproperty
  a_nav_cs: assert property (p_nav_cs) else $error("virtual busy ignored by spacing"); // R16
endmodule : chan_access_timing

// ### pkg/chan_timing_pkg.sv
// Types shared by the channel-access timing core
`include "chan_timing_regs.svh"
package chan_timing_pkg;
  typedef enum logic [2:0] {TSF_NOP, TSF_LOAD, TSF_ADVANCE, TSF_SET_BEACON_TARGET_TIME, TSF_SET_UL, TSF_SET_DL} tsf_op_type;
  typedef enum logic [1:0] {PWR_AWAKE, PWR_SLEEP} pwr_state_type;
  typedef struct packed {
    logic                     load;
    logic [1:0]               ac;
    logic [`BO_W-1:0]         value;
  } bo_cmd_type;
  typedef struct packed {
    logic [`AC_NUM-1:0][1:0]  rank;
    logic                     use_rifs;
  } policy_type;
  typedef struct packed {
    tsf_op_type               op;
    logic [`TSF_W-1:0]        value;
  } tsf_cmd_type;
  typedef struct packed {
    logic                     update;
    logic [`NAV_W-1:0]        duration;
  } nav_cmd_type;
  typedef struct packed {
    logic                     load;
    logic                     enter;
    logic [`SLEEP_W-1:0]      count;
  } sleep_cmd_type;
  typedef struct packed {
    logic                     sched;
    logic                     response;
    logic [1:0]               ac;
  } tx_req_type;
endpackage : chan_timing_pkg

// ### pkg/chan_timing_regs.svh
// Timing constants and widths of the channel-access timing core
`ifndef CHAN_TIMING_REGS_SVH
`define CHAN_TIMING_REGS_SVH
`define CLK_PERIOD_NS 4
`define SIFS_US 16
`define RIFS_US 2
`define SLOT_US 9
`define US_NS 1000
`define SIFS_CYC ((`SIFS_US * `US_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RIFS_CYC ((`RIFS_US * `US_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SLOT_CYC ((`SLOT_US * `US_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define US_CYC (`US_NS / `CLK_PERIOD_NS)
`define TMR_W 12
`define AC_NUM 4
`define BO_W 10
`define NAV_W 16
`define TSF_W 64
`define SLEEP_W 24
`define RST_ZERO 1'b0
`endif

// ### sim/medium_model.sv
// Far-side model: PHY activity indication and free-running slow clock
`timescale 1ns/1ps
module medium_model #(
  parameter int SLOW_HALF = 16
) (
  // Clock
  input  wire logic clk,
  // Bench control
  input  wire logic busy_req,
  // Pins towards the core
  output logic      phy_busy,
  output logic      slow_clk
);
  int unsigned div_q;
  initial begin
    phy_busy = 1'b0;
    slow_clk = 1'b0;
    div_q    = 0;
  end
  // Activity lags the request by one edge, as a real receiver lags the air
  always @(posedge clk) begin
    phy_busy <= busy_req;
  end
  // Low-power oscillator runs free, far slower than clk
  always @(posedge clk) begin
    if (div_q == SLOW_HALF - 1) begin
      div_q    <= 0;
      slow_clk <= ~slow_clk;
    end else begin
      div_q <= div_q + 1;
    end
  end
endmodule : medium_model

// ### sim/tb.sv
// Self-checking bench of the channel-access timing core
`timescale 1ns/1ps
`include "chan_timing_regs.svh"
module tb;
  logic                           clk;
  logic                           sys_rst;
  logic                           clk_en;
  logic                           busy_req;
  logic                           phy_busy;
  logic                           slow_clk;
  chan_timing_pkg::policy_type    policy;
  chan_timing_pkg::bo_cmd_type    bo_cmd;
  chan_timing_pkg::tsf_cmd_type   tsf_cmd;
  chan_timing_pkg::nav_cmd_type   nav_cmd;
  chan_timing_pkg::sleep_cmd_type sleep_cmd;
  chan_timing_pkg::tx_req_type    tx_req;
  logic                           tx_start;
  logic [1:0]                     tx_start_ac;
  logic [`AC_NUM-1:0]             bo_notify;
  logic                           ifs_trig;
  logic [`TSF_W-1:0]              tsf_time;
  logic [2:0]                     tsf_evt;
  logic                           nav_busy;
  logic [`SLEEP_W-1:0]            slept_ticks;
  logic                           wake_evt;
  logic                           mac_clk_en;
  int                             error_cnt;
  int                             n_checks;
  int                             cyc;
  int                             n;
  int                             hits;

  chan_access_timing uut (
    .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .phy_busy(phy_busy), .slow_clk(slow_clk),
    .policy(policy), .bo_cmd(bo_cmd), .tsf_cmd(tsf_cmd), .nav_cmd(nav_cmd), .sleep_cmd(sleep_cmd),
    .tx_req(tx_req), .tx_start(tx_start), .tx_start_ac(tx_start_ac), .bo_notify(bo_notify),
    .ifs_trig(ifs_trig), .tsf_time(tsf_time), .tsf_evt(tsf_evt), .nav_busy(nav_busy),
    .slept_ticks(slept_ticks), .wake_evt(wake_evt), .mac_clk_en(mac_clk_en)
  );
  medium_model far (.clk(clk), .busy_req(busy_req), .phy_busy(phy_busy), .slow_clk(slow_clk));

  always #2 clk = ~clk;

  // A hang must still end in the verdict
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      error_cnt++;
      test_done();
    end
  end

  task automatic check(input logic [71:0] got, input logic [71:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  function automatic logic seen(input int sel);
    case (sel)
      0: return ifs_trig;
      1: return |bo_notify;
      2: return |tsf_evt;
      3: return wake_evt;
      default: return ~nav_busy;
    endcase
  endfunction : seen

  task automatic wait_for(input int sel, input int lim);
    n = 0;
    while (seen(sel) !== 1'b1 && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask : wait_for

  task automatic burst(input int len);
    @(posedge clk) busy_req <= 1'b1;
    repeat (len) @(posedge clk);
    busy_req <= 1'b0;
  endtask : burst

  task automatic pulse_nav(input logic [15:0] d);
    @(posedge clk) nav_cmd <= '{update: 1'b1, duration: d};
    @(posedge clk) nav_cmd <= '0;
    #1;
  endtask : pulse_nav

  task automatic pulse_bo(input logic [1:0] ac, input logic [9:0] v);
    @(posedge clk) bo_cmd <= '{load: 1'b1, ac: ac, value: v};
    @(posedge clk) bo_cmd <= '0;
  endtask : pulse_bo

  task automatic pulse_tx(input logic resp, input logic [1:0] ac);
    @(posedge clk) tx_req <= '{sched: 1'b1, response: resp, ac: ac};
    @(posedge clk) tx_req <= '0;
  endtask : pulse_tx

  task automatic pulse_tsf(input chan_timing_pkg::tsf_op_type op, input logic [63:0] v);
    @(posedge clk) tsf_cmd <= '{op: op, value: v};
    @(posedge clk) tsf_cmd <= '{op: chan_timing_pkg::TSF_NOP, value: 64'h0};
    #1;
  endtask : pulse_tsf

  task automatic t_nav;
    pulse_nav(16'h0005);
    check(nav_busy, 1'b1);
    // A shorter duration must not cut the reservation short
    pulse_nav(16'h0002);
    repeat (3 * `US_CYC + 200) @(posedge clk);
    #1;
    check(nav_busy, 1'b1);
    wait_for(4, 2 * `US_CYC);
    check(nav_busy, 1'b0);
    $display("t_nav done");
  endtask : t_nav

  task automatic t_spacing(input logic rifs, input int expc);
    @(posedge clk) policy <= '{rank: 8'h93, use_rifs: rifs};
    pulse_tx(1'b1, 2'h0);
    burst(8);
    wait_for(0, expc + 8);
    check(n >= expc && n <= expc + 8, 1'b1);
    @(posedge clk);
    #1;
    check({tx_start, tx_start_ac}, 3'h4);
    $display("t_spacing done");
  endtask : t_spacing

  task automatic t_virtual;
    pulse_nav(16'h0014);
    burst(8);
    wait_for(0, `SIFS_CYC + 8);
    check(ifs_trig, 1'b0);
    wait_for(4, 6000);
    $display("t_virtual done");
  endtask : t_virtual

  task automatic t_backoff;
    pulse_bo(2'h0, 10'h001);
    pulse_bo(2'h1, 10'h001);
    pulse_tx(1'b0, 2'h1);
    burst(8);
    wait_for(1, `SIFS_CYC + 2 * `SLOT_CYC + 20);
    check(bo_notify, 4'h3);
    @(posedge clk);
    #1;
    check({tx_start, tx_start_ac}, 3'h5);
    // Busy medium across whole slots must freeze the count
    @(posedge clk) busy_req <= 1'b1;
    repeat (4) @(posedge clk);
    pulse_bo(2'h2, 10'h001);
    hits = 0;
    repeat (2 * `SLOT_CYC) begin
      @(posedge clk);
      #1;
      if (bo_notify !== 4'h0) hits++;
    end
    check(hits, 0);
    @(posedge clk) busy_req <= 1'b0;
    wait_for(1, `SIFS_CYC + 2 * `SLOT_CYC + 20);
    check(bo_notify, 4'h4);
    $display("t_backoff done");
  endtask : t_backoff

  task automatic t_tsf;
    pulse_tsf(chan_timing_pkg::TSF_LOAD, 64'h100);
    check(tsf_time, 64'h100);
    pulse_tsf(chan_timing_pkg::TSF_SET_BEACON_TARGET_TIME, 64'h102);
    pulse_tsf(chan_timing_pkg::TSF_SET_UL, 64'h103);
    pulse_tsf(chan_timing_pkg::TSF_SET_DL, 64'h104);
    for (int i = 0; i < 3; i++) begin
      wait_for(2, 2 * `US_CYC + 10);
      check({tsf_evt, tsf_time}, {3'h1 << i, 64'h102 + i});
      @(posedge clk);
      #1;
    end
    $display("t_tsf done");
  endtask : t_tsf

  task automatic t_sleep;
    @(posedge clk) sleep_cmd <= '{load: 1'b1, enter: 1'b0, count: 24'h3};
    @(posedge clk) sleep_cmd <= '{load: 1'b0, enter: 1'b1, count: 24'h0};
    @(posedge clk) sleep_cmd <= '0;
    #1;
    check(mac_clk_en, 1'b0);
    wait_for(3, 200);
    check({mac_clk_en, wake_evt}, 2'h3);
    @(posedge clk);
    #1;
    check(slept_ticks, 24'h3);
    // Sequencer re-aligns the timer by the slept time
    @(posedge clk) tsf_cmd <= '{op: chan_timing_pkg::TSF_LOAD, value: 64'h200};
    @(posedge clk) tsf_cmd <= '{op: chan_timing_pkg::TSF_ADVANCE, value: {40'h0, slept_ticks}};
    @(posedge clk) tsf_cmd <= '{op: chan_timing_pkg::TSF_NOP, value: 64'h0};
    #1;
    check(tsf_time, 64'h203);
    $display("t_sleep done");
  endtask : t_sleep

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done

  initial begin
    clk       = 1'b0;
    sys_rst   = 1'b1;
    clk_en    = 1'b1;
    busy_req  = 1'b0;
    policy    = '{rank: 8'h93, use_rifs: 1'b0};
    bo_cmd    = '0;
    tsf_cmd   = '{op: chan_timing_pkg::TSF_NOP, value: 64'h0};
    nav_cmd   = '0;
    sleep_cmd = '0;
    tx_req    = '0;
    error_cnt = 0;
    n_checks  = 0;
    cyc       = 0;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    check({mac_clk_en, nav_busy, tsf_time}, {2'h2, 64'h0});
    t_nav();
    t_spacing(1'b1, `RIFS_CYC);
    t_spacing(1'b0, `SIFS_CYC);
    t_virtual();
    t_backoff();
    t_tsf();
    t_sleep();
    test_done();
  end
endmodule : tb
